// >>> tgp_consts.vh
// Register map, reset values and timing constants of the timing pulse generator.
`ifndef TGP_CONSTS_VH
`define TGP_CONSTS_VH

// Record byte positions; the bus address is four times the index.
`define TGP_IDX_TRIGGER    4'h0
`define TGP_IDX_POLARITY   4'h1
`define TGP_IDX_RATE_FORM  4'h2
`define TGP_IDX_RESERVED   4'h3
`define TGP_IDX_INTERVAL   4'h4
`define TGP_IDX_ACTIVE     4'h8
`define TGP_IDX_SHIFT      4'hC
`define TGP_IDX_STATUS     4'hD

`define TGP_RST_TRIGGER    8'h00
`define TGP_RST_POLARITY   8'h01
`define TGP_RST_RATE_FORM  8'h00
`define TGP_RST_INTERVAL   32'h000F4240
`define TGP_RST_ACTIVE     32'h000186A0
`define TGP_RST_SHIFT      32'h00000000

`define TGP_MODE_OFF       8'h00
`define TGP_MODE_FREE      8'h01
`define TGP_MODE_LOCKED    8'h02

`define TGP_CLK_PERIOD_NS  32'h0000000A
`define TGP_CLK_HZ         64'h0000000005F5E100
`define TGP_NS_PER_SEC     34'h03B9ACA00
`define TGP_NS_PER_US      32'h000003E8
`define TGP_CYC_PER_US     (`TGP_NS_PER_US / `TGP_CLK_PERIOD_NS)
// Phase step per hertz for a 48-bit accumulator.
`define TGP_NCO_STEP       (64'h0001000000000000 / `TGP_CLK_HZ)

`define TGP_RESP_OKAY      2'h0
`define TGP_RESP_SLVERR    2'h2

`endif

// >>> tgp_pulse_gen.v
// Timing pulse generator aligned to receiver seconds, with an AXI4-Lite register slave.
`include "tgp_consts.vh"

module tgp_pulse_gen #(
  parameter ADDR_W = 6
) (
  input  wire              clk,
  input  wire              arst_n,
  input  wire              rx_time_fix,
  input  wire              rx_second_pulse,
  output reg               timing_pulse_out,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  localparam [63:0] NCO_STEP_W = `TGP_NCO_STEP;
  localparam [31:0] CYC_US_W   = `TGP_CYC_PER_US;
  // Both constants fit their narrow forms, so the cut keeps every set bit.
  localparam [47:0] NCO_STEP   = NCO_STEP_W[47:0];
  localparam [7:0]  CYC_US     = CYC_US_W[7:0];

  // Configuration record.
  reg  [7:0]  pulse_trigger_select;
  reg  [7:0]  edge_polarity;
  reg  [7:0]  rate_form_select;
  reg  [31:0] interval_or_rate;
  reg  [31:0] active_time_or_fraction;
  reg  [31:0] second_alignment_shift;

  // Merges a write into a word under its byte strobes.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Maps a byte address to a register index; 4'hF marks an unmapped address.
  function [3:0] decode;
    input [ADDR_W-1:0] addr;
    reg   [3:0]        idx;
    begin
      idx = addr[5:2];
      if (addr[1:0] != 2'h0) begin
        decode = 4'hF;
      end else if (idx == `TGP_IDX_TRIGGER) begin
        decode = `TGP_IDX_TRIGGER;
      end else if (idx == `TGP_IDX_POLARITY) begin
        decode = `TGP_IDX_POLARITY;
      end else if (idx == `TGP_IDX_RATE_FORM) begin
        decode = `TGP_IDX_RATE_FORM;
      end else if (idx == `TGP_IDX_RESERVED) begin
        decode = `TGP_IDX_RESERVED;
      end else if (idx == `TGP_IDX_INTERVAL) begin
        decode = `TGP_IDX_INTERVAL;
      end else if (idx == `TGP_IDX_ACTIVE) begin
        decode = `TGP_IDX_ACTIVE;
      end else if (idx == `TGP_IDX_SHIFT) begin
        decode = `TGP_IDX_SHIFT;
      end else if (idx == `TGP_IDX_STATUS) begin
        decode = `TGP_IDX_STATUS;
      end else begin
        decode = 4'hF;
      end
    end
  endfunction

  // Write channel: address and data are taken in either order.
  reg  [ADDR_W-1:0] aw_addr;
  reg               aw_held;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;
  reg               w_held;
  wire [3:0]        w_idx = decode(aw_addr);
  wire              do_write = aw_held && w_held && !s_axi_bvalid;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_addr                 <= {ADDR_W{1'b0}};
      aw_held                 <= 1'b0;
      w_data                  <= 32'h00000000;
      w_strb                  <= 4'h0;
      w_held                  <= 1'b0;
      s_axi_awready           <= 1'b1;
      s_axi_wready            <= 1'b1;
      s_axi_bvalid            <= 1'b0;
      s_axi_bresp             <= `TGP_RESP_OKAY;
      pulse_trigger_select    <= `TGP_RST_TRIGGER;
      edge_polarity           <= `TGP_RST_POLARITY;
      rate_form_select        <= `TGP_RST_RATE_FORM;
      interval_or_rate        <= `TGP_RST_INTERVAL;
      active_time_or_fraction <= `TGP_RST_ACTIVE;
      second_alignment_shift  <= `TGP_RST_SHIFT;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (w_idx == 4'hF) ? `TGP_RESP_SLVERR : `TGP_RESP_OKAY;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        if (w_idx == `TGP_IDX_TRIGGER) begin
          pulse_trigger_select <= w_strb[0] ? w_data[7:0] : pulse_trigger_select;
        end else if (w_idx == `TGP_IDX_POLARITY) begin
          edge_polarity <= w_strb[0] ? w_data[7:0] : edge_polarity;
        end else if (w_idx == `TGP_IDX_RATE_FORM) begin
          rate_form_select <= w_strb[0] ? w_data[7:0] : rate_form_select;
        end else if (w_idx == `TGP_IDX_INTERVAL) begin
          interval_or_rate <= merge(interval_or_rate, w_data, w_strb);
        end else if (w_idx == `TGP_IDX_ACTIVE) begin
          active_time_or_fraction <= merge(active_time_or_fraction, w_data, w_strb);
        end else if (w_idx == `TGP_IDX_SHIFT) begin
          second_alignment_shift <= merge(second_alignment_shift, w_data, w_strb);
        end else if (w_idx == `TGP_IDX_RESERVED || w_idx == `TGP_IDX_STATUS) begin
          // The reserved byte is not stored and the status word is read-only.
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Receiver time inputs arrive from another domain and pass two flip-flops first.
  reg  fix_meta;
  reg  fix_sync;
  reg  sec_meta;
  reg  sec_sync;
  reg  sec_last;
  wire sec_edge = sec_sync && !sec_last;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fix_meta <= 1'b0;
      fix_sync <= 1'b0;
      sec_meta <= 1'b0;
      sec_sync <= 1'b0;
      sec_last <= 1'b0;
    end else begin
      fix_meta <= rx_time_fix;
      fix_sync <= fix_meta;
      sec_meta <= rx_second_pulse;
      sec_sync <= sec_meta;
      sec_last <= sec_sync;
    end
  end

  // Nanosecond position within the receiver second. It restarts on every receiver
  // second mark, so a time correction moves the pulse edges abruptly.
  reg  [33:0] ns_count;
  wire [33:0] ns_step = {2'b00, `TGP_CLK_PERIOD_NS};

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ns_count <= 34'h000000000;
    end else if (sec_edge) begin
      ns_count <= 34'h000000000;
    end else if (ns_count + ns_step >= `TGP_NS_PER_SEC) begin
      ns_count <= ns_count + ns_step - `TGP_NS_PER_SEC;
    end else begin
      ns_count <= ns_count + ns_step;
    end
  end

  // Folds the signed shift into one second; two folds cover shifts from -2000000000 up to the int32 maximum.
  reg [33:0] shift_a;
  reg [33:0] align_ns;

  always @* begin
    shift_a  = {{2{second_alignment_shift[31]}}, second_alignment_shift};
    align_ns = shift_a;
    if (shift_a[33]) begin
      align_ns = shift_a + `TGP_NS_PER_SEC;
      if (align_ns[33]) begin
        align_ns = align_ns + `TGP_NS_PER_SEC;
      end
    end else if (shift_a >= `TGP_NS_PER_SEC) begin
      align_ns = shift_a - `TGP_NS_PER_SEC;
      if (align_ns >= `TGP_NS_PER_SEC) begin
        align_ns = align_ns - `TGP_NS_PER_SEC;
      end
    end
  end

  wire align_hit = (align_ns >= ns_count) && (align_ns < ns_count + ns_step);

  // Gating by trigger mode. Mode values above two are treated as off, so an
  // unknown setting from newer software can never start the pin.
  wire run = (pulse_trigger_select == `TGP_MODE_FREE) ||
             (pulse_trigger_select == `TGP_MODE_LOCKED && fix_sync);

  // Microsecond form: a cycle counter over period*100 cycles, active for width*100.
  // A period of zero pins the counter at zero, so the output then stays active
  // whenever the width is nonzero.
  reg  [39:0] us_count;
  wire [39:0] us_period = interval_or_rate * CYC_US;
  wire [39:0] us_width  = active_time_or_fraction * CYC_US;
  wire        us_active = (us_count < us_width);

  // Frequency form: a 48-bit phase accumulator stepped in proportion to the rate.
  reg  [47:0] phase;
  wire [47:0] phase_inc = interval_or_rate * NCO_STEP;
  wire        hz_active = (active_time_or_fraction == 32'hFFFFFFFF) ||
                          (phase[47:16] < active_time_or_fraction);

  wire use_hz = (rate_form_select != 8'h00);
  wire active = use_hz ? hz_active : us_active;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      us_count <= 40'h0000000000;
      phase    <= 48'h000000000000;
    end else if (!run || align_hit) begin
      us_count <= 40'h0000000000;
      phase    <= 48'h000000000000;
    end else begin
      phase <= phase + phase_inc;
      if (us_count + 40'h0000000001 >= us_period) begin
        us_count <= 40'h0000000000;
      end else begin
        us_count <= us_count + 40'h0000000001;
      end
    end
  end

  // Active level is high for rising-edge polarity, low for falling-edge polarity.
  wire active_level = (edge_polarity != 8'h00);

  // Whenever the generator is not running the pin rests at the inactive level, so a
  // mode change or a lost fix never leaves a pulse standing.
  reg next_pulse;

  always @* begin
    next_pulse = !active_level;
    if (run && active) begin
      next_pulse = active_level;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timing_pulse_out <= 1'b0;
    end else begin
      timing_pulse_out <= next_pulse;
    end
  end

  // Read channel with a fixed one-cycle answer.
  wire [3:0] r_idx = decode(s_axi_araddr);
  reg  [31:0] next_rdata;
  // Status bits: synced fix, running, and the pin as it stands now.
  wire [31:0] status_word = {29'h00000000, timing_pulse_out, run, fix_sync};

  always @* begin
    next_rdata = 32'h00000000;
    if (r_idx == `TGP_IDX_TRIGGER) begin
      next_rdata = {24'h000000, pulse_trigger_select};
    end else if (r_idx == `TGP_IDX_POLARITY) begin
      next_rdata = {24'h000000, edge_polarity};
    end else if (r_idx == `TGP_IDX_RATE_FORM) begin
      next_rdata = {24'h000000, rate_form_select};
    end else if (r_idx == `TGP_IDX_INTERVAL) begin
      next_rdata = interval_or_rate;
    end else if (r_idx == `TGP_IDX_ACTIVE) begin
      next_rdata = active_time_or_fraction;
    end else if (r_idx == `TGP_IDX_SHIFT) begin
      next_rdata = second_alignment_shift;
    end else if (r_idx == `TGP_IDX_STATUS) begin
      next_rdata = status_word;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `TGP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= next_rdata;
        s_axi_rresp   <= (r_idx == 4'hF) ? `TGP_RESP_SLVERR : `TGP_RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// >>> tgp_pulse_gen_props.sv
// Concurrent checks on the bus and pulse pins of the timing pulse generator.
module tgp_pulse_gen_props #(
  parameter ADDR_W = 6
) (
  input logic              clk,
  input logic              arst_n,
  input logic              rx_time_fix,
  input logic              timing_pulse_out,
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic              s_axi_awvalid,
  input logic              s_axi_awready,
  input logic [31:0]       s_axi_wdata,
  input logic              s_axi_bvalid,
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic [31:0]       s_axi_rdata,
  input logic [1:0]        s_axi_rresp,
  input logic              s_axi_rvalid,
  input logic              s_axi_rready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [7:0] mode;
  logic [7:0] pol;
  sequence s_aw;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_ar;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Shadows are only sound because the bench offers address and data in the same cycle.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= 8'h00;
      pol  <= 8'h01;
    end else if (s_axi_awvalid && s_axi_awready) begin
      if (s_axi_awaddr == 'h0) mode <= s_axi_wdata[7:0];
      if (s_axi_awaddr == 'h4) pol <= s_axi_wdata[7:0];
    end
  end
  a_write_answer: assert property (s_aw |-> ##[1:4] s_axi_bvalid)
    else $error("no write response");
  a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  a_read_answer: assert property (s_ar |=> s_axi_rvalid)
    else $error("no read response");
  a_r_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_unmapped_err: assert property (s_ar ##0 s_axi_araddr == 'h3C |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  a_resv_zero: assert property (s_ar ##0 s_axi_araddr == 'hC |=> s_axi_rdata == 32'h0)
    else $error("reserved byte not zero");
  a_off_quiet: assert property ((mode == 8'h00 && $stable(pol))[*8] |->
    timing_pulse_out == (pol == 8'h00)) else $error("pulse while off");
  a_lock_gate: assert property ((mode == 8'h02 && !rx_time_fix && $stable(pol))[*8] |->
    timing_pulse_out == (pol == 8'h00)) else $error("pulse without fix");
endmodule
bind tgp_pulse_gen tgp_pulse_gen_props #(.ADDR_W(ADDR_W)) u_props (.*);

// >>> tgp_pulse_sink.sv
// Consuming equipment: counts active cycles and pulse starts on the sync output.
module tgp_pulse_sink (
  input  logic        clk,
  input  logic        act_hi,
  input  logic        pulse,
  input  logic        clr,
  output logic [31:0] act_cnt,
  output logic [31:0] start_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl;
  logic prev = 1'b0;
  // One counter serves both senses because the active level follows the polarity.
  assign lvl = (pulse == act_hi);
  always @(posedge clk) begin
    prev <= lvl;
    if (clr) begin
      act_cnt   <= 32'h0;
      start_cnt <= 32'h0;
    end else begin
      act_cnt   <= act_cnt + {31'h0, lvl};
      start_cnt <= start_cnt + {31'h0, lvl && !prev};
    end
  end
endmodule

// >>> tgp_pulse_gen_bench.sv
// Self-checking bench for the timing pulse generator.
`include "tgp_consts.vh"
module tgp_pulse_gen_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 0, arst_n = 0, rx_time_fix = 0, rx_second_pulse = 0, clr = 0, act_hi = 1;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        timing_pulse_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [5:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, act, st, seed, d, v;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  idx [7];
  logic [31:0] rstv [7];
  int          fail_count = 0, checks_done = 0, n;
  tgp_pulse_gen dut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hF), .*);
  tgp_pulse_sink u_sink (.clk(clk), .act_hi(act_hi), .pulse(timing_pulse_out), .clr(clr),
    .act_cnt(act), .start_cnt(st));
  always #5 clk = ~clk;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic int exp_act(input int per, input int wid, input int win);
    return win / per * wid;
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    checks_done++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] val);
    seed = lfsr(seed);
    s_axi_awaddr  <= {i, 2'b00};
    s_axi_wdata   <= val;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= seed[3];
    n = 0;
    do begin
      @(posedge clk);
      n++;
      s_axi_bready <= 1;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 64);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    if (n >= 64) begin
      chk("write answer", 1, 0);
      give_verdict;
    end
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a);
    seed = lfsr(seed);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    s_axi_rready  <= seed[5];
    n = 0;
    do begin
      @(posedge clk);
      n++;
      s_axi_rready <= 1;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 64);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    if (n >= 64) begin
      chk("read answer", 1, 0);
      give_verdict;
    end
    @(posedge clk);
  endtask
  task automatic meas;
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    repeat (2000) @(posedge clk);
  endtask
  initial begin
    seed = 32'h2EDD;
    idx  = '{`TGP_IDX_TRIGGER, `TGP_IDX_POLARITY, `TGP_IDX_RATE_FORM, `TGP_IDX_RESERVED,
             `TGP_IDX_INTERVAL, `TGP_IDX_ACTIVE, `TGP_IDX_SHIFT};
    rstv = '{`TGP_RST_TRIGGER, `TGP_RST_POLARITY, `TGP_RST_RATE_FORM, 0, `TGP_RST_INTERVAL,
             `TGP_RST_ACTIVE, `TGP_RST_SHIFT};
    repeat (20) @(posedge clk);
    arst_n <= 1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rd({idx[i], 2'b00});
      chk("reset value", rstv[i], d);
    end
    rd(6'h34);
    chk("status idle", 0, d);
    rd(6'h3C);
    chk("unmapped resp", {30'h0, `TGP_RESP_SLVERR}, {30'h0, r});
    wr(4'hF, 32'h0);
    chk("unmapped wresp", {30'h0, `TGP_RESP_SLVERR}, {30'h0, r});
    wr(`TGP_IDX_RESERVED, 32'h0);
    chk("reserved wresp", {30'h0, `TGP_RESP_OKAY}, {30'h0, r});
    rd({`TGP_IDX_RESERVED, 2'b00});
    chk("reserved read", 0, d);
    for (int i = 4; i < 7; i++) begin
      v = lfsr(seed);
      wr(idx[i], v);
      rd({idx[i], 2'b00});
      chk("readback", v, d);
    end
    wr(`TGP_IDX_INTERVAL, 32'h2);
    wr(`TGP_IDX_ACTIVE, 32'h1);
    wr(`TGP_IDX_SHIFT, 32'h0);
    meas;
    chk("starts off", 0, st);
    chk("idle level", 0, {31'h0, timing_pulse_out});
    wr(`TGP_IDX_TRIGGER, `TGP_MODE_FREE);
    meas;
    chk_rng("starts free", 9, 11, st);
    chk_rng("active us", exp_act(200, 100, 2000) - 3, exp_act(200, 100, 2000) + 1, act);
    wr(`TGP_IDX_POLARITY, 32'h0);
    act_hi <= 0;
    meas;
    chk_rng("active low", exp_act(200, 100, 2000) - 3, exp_act(200, 100, 2000) + 1, act);
    wr(`TGP_IDX_POLARITY, 32'h1);
    act_hi <= 1;
    wr(`TGP_IDX_RATE_FORM, 32'h1);
    wr(`TGP_IDX_INTERVAL, 32'h0007A120);
    wr(`TGP_IDX_ACTIVE, 32'h80000000);
    meas;
    chk_rng("active hz", exp_act(200, 100, 2000) - 4, exp_act(200, 100, 2000) + 3, act);
    wr(`TGP_IDX_ACTIVE, 32'hFFFFFFFF);
    meas;
    chk_rng("full duty", 1996, 2000, act);
    wr(`TGP_IDX_RATE_FORM, 32'h0);
    wr(`TGP_IDX_TRIGGER, `TGP_MODE_LOCKED);
    wr(`TGP_IDX_INTERVAL, 32'h3E8);
    wr(`TGP_IDX_ACTIVE, 32'hA);
    wr(`TGP_IDX_SHIFT, 32'h1388);
    meas;
    chk("starts unlocked", 0, st);
    rx_time_fix <= 1;
    repeat (1500) @(posedge clk);
    rd(6'h34);
    chk("status locked", 32'h3, d);
    rx_second_pulse <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n == 4) rx_second_pulse <= 0;
    end while (timing_pulse_out !== 1'b1 && n < 1000);
    chk_rng("offset delay", 500, 510, n);
    rx_time_fix <= 0;
    meas;
    chk("starts lost fix", 0, st);
    give_verdict;
  end
endmodule
